// ### pci_dac_pkg.sv
// Shared constants for the dual-address-cycle PCI write sequencer.
// Contract
// - Local master requests with address, command, length.
// - Bus request asserts one cycle after local request.
// - Local grant asserts on bus grant and idle.
// - Request plus grant moves status to address loading.
// - Low address cycle drives frame, address, DAC.
// - Local master drops request after address loading.
// - Local master supplies high address during low cycle.
// - Burst counter loads length in first address cycle.
// - Bus request drops after frame without local request.
// - High address cycle drives address, command, transaction status.
// - Ready then first data: word taken strobe asserts.
// - Local ready asserts only when data available.
// - Wait cycle keeps taken strobe for word two.
// - First data phase asserts IRDY, drops taken strobe.
// - Frame held; IRDY and TRDY complete phases.
// - Each completed phase decrements counter, drives next word.
// - Ready last cycle keeps IRDY asserted.
// - Ready and TRDY last cycle assert taken strobe.
// - Local ready drops after final word presented.
// - Last data phase drops frame and taken strobe.
// - Turnaround releases bus, zeroes count, reports termination.
package pci_dac_pkg;
   localparam int ADDR_W = 32;            // Width of one address or data word.
   localparam int BE_W = 4;               // Width of command or byte enables.
   localparam int LEN_W = 11;             // Width of the burst length field.
   localparam int WORD_W = ADDR_W + BE_W; // Data plus byte enables.
   localparam int QUEUE_DEPTH = 4;        // Words staged inside the device.
   localparam int FIFO_DEPTH = 16;        // Words buffered at the local side.
   // Status codes on the local status output.
   localparam logic [3:0] STAT_IDLE = 4'h0;
   localparam logic [3:0] STAT_ADDR_LOAD = 4'h1;
   localparam logic [3:0] STAT_BUS_TRANS = 4'h2;
   localparam logic [3:0] STAT_BUS_TERM = 4'h3;
   // Termination reasons reported at the end of a transaction.
   localparam logic [1:0] END_NONE = 2'h0;
   localparam logic [1:0] END_NORMAL = 2'h1;
   // Bus commands used by the local master.
   localparam logic [3:0] CMD_DAC = 4'hd;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
endpackage : pci_dac_pkg

// ### local_master_if.sv
// Interface joining the local master logic to the PCI write sequencer.
`timescale 1ns/1ns
interface local_master_if;
   import pci_dac_pkg::*;
   logic local_req_32bit_n;                    // Transaction request.
   logic [ADDR_W-1:0] localAdIn;               // Address or data word.
   logic [BE_W-1:0] local_cmd_byte_en_in;      // Command or byte enables.
   logic [LEN_W-1:0] local_burst_len;          // Data words in the burst.
   logic local_ready_n;                        // Local master can supply.
   logic local_grant_n;                        // Bus request granted.
   logic [3:0] local_master_state;             // Sequencer status code.
   logic local_word_taken_n;                   // Word is being sampled.
   logic [1:0] local_end_reason;               // How the burst ended.
   logic [LEN_W-1:0] remaining_burst_count;    // Data phases still due.
   // The sequencer end of the link.
   modport device (
      input local_req_32bit_n, localAdIn, local_cmd_byte_en_in,
      input local_burst_len, local_ready_n,
      output local_grant_n, local_master_state, local_word_taken_n,
      output local_end_reason, remaining_burst_count
   );
   // The local master end of the link.
   modport master (
      output local_req_32bit_n, localAdIn, local_cmd_byte_en_in,
      output local_burst_len, local_ready_n,
      input local_grant_n, local_master_state, local_word_taken_n,
      input local_end_reason, remaining_burst_count
   );
endinterface : local_master_if

// ### local_master_end.sv
// Write-data FIFO and the local master that feeds the sequencer.
`timescale 1ns/1ns
module word_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];      // Word storage.
   logic [PTR_W-1:0] wrPtr_reg;        // Next slot to write.
   logic [PTR_W-1:0] rdPtr_reg;        // Oldest stored word.
   logic [PTR_W:0] count_reg;          // Words held.
   logic doPush;                       // A word enters this cycle.
   logic doPop;                        // A word leaves this cycle.
   assign inReady = count_reg != DEPTH[PTR_W:0];
   assign outValid = count_reg != '0;
   assign outData = mem[rdPtr_reg];
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;
   // Storage is written without reset; only the pointers and fill level need one.
   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_reg] <= inData;
      end
   end
   // Pointers and fill level track pushes and pops.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doPush) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (doPop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (doPush && !doPop) begin
            count_reg <= count_reg + 1'b1;
         end else if (doPop && !doPush) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // word_fifo

module local_master_end
   import pci_dac_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   local_master_if.master lm,
   input wire logic userStart,
   input wire logic [2*ADDR_W-1:0] userAddr,
   input wire logic [LEN_W-1:0] userLen,
   output logic userBusy,
   output logic userDone,
   input wire logic [WORD_W-1:0] wrData,
   input wire logic wrValid,
   output logic wrReady
);
   typedef enum logic [2:0] {LM_IDLE, LM_REQ, LM_HIGH, LM_DATA}
      lm_state_type;
   lm_state_type state_reg;            // Local master sequence.
   logic reqN_reg;                     // Request to the sequencer.
   logic [ADDR_W-1:0] ad_reg;          // Word on the address/data lines.
   logic [BE_W-1:0] cbe_reg;           // Command or byte enables.
   logic [LEN_W-1:0] len_reg;          // Burst length being offered.
   logic [LEN_W-1:0] left_reg;         // Words not yet handed over.
   logic [ADDR_W-1:0] highAddr_reg;    // Upper address half.
   logic headValid_reg;                // A data word is on the lines.
   logic done_reg;                     // End-of-burst pulse.
   logic [WORD_W-1:0] fifoData;        // FIFO head word.
   logic fifoValid;                    // FIFO holds a word.
   logic handed;                       // Sequencer took the head word.
   logic loadHead;                     // Next word moves onto the lines.
   word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) dataFifo (
      .clock(clock),
      .arst_n(arst_n),
      .inData(wrData),
      .inValid(wrValid),
      .inReady(wrReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(loadHead)
   );
   assign handed = !lm.local_word_taken_n && !lm.local_ready_n;
   // A new word is loaded at the high address step, when no word is on the lines, or after a handover.
   assign loadHead = fifoValid && ((state_reg == LM_HIGH) ||
      (state_reg == LM_DATA && (!headValid_reg || handed) &&
      left_reg > LEN_W'(handed ? 1 : 0)));
   // Ready only while a real data word is or will be presented.
   assign lm.local_ready_n = !((state_reg == LM_HIGH && fifoValid) ||
      (state_reg == LM_DATA && headValid_reg));
   assign lm.local_req_32bit_n = reqN_reg;
   assign lm.localAdIn = ad_reg;
   assign lm.local_cmd_byte_en_in = cbe_reg;
   assign lm.local_burst_len = len_reg;
   assign userBusy = state_reg != LM_IDLE;
   assign userDone = done_reg;
   // Sequence of request, address halves and data words.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= LM_IDLE;
         reqN_reg <= 1'b1;
         ad_reg <= '0;
         cbe_reg <= '0;
         len_reg <= '0;
         left_reg <= '0;
         highAddr_reg <= '0;
         headValid_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            LM_IDLE: begin
               // Request, address, command and length go out together.
               if (userStart) begin
                  reqN_reg <= 1'b0;
                  ad_reg <= userAddr[ADDR_W-1:0];
                  highAddr_reg <= userAddr[2*ADDR_W-1:ADDR_W];
                  cbe_reg <= CMD_DAC;
                  len_reg <= userLen;
                  left_reg <= userLen;
                  state_reg <= LM_REQ;
               end
            end
            LM_REQ: begin
               // Address loading seen: drop request, offer high half.
               if (lm.local_master_state == STAT_ADDR_LOAD) begin
                  reqN_reg <= 1'b1;
                  ad_reg <= highAddr_reg;
                  cbe_reg <= CMD_MEM_WRITE;
                  state_reg <= LM_HIGH;
               end
            end
            LM_HIGH: begin
               state_reg <= LM_DATA;
            end
            default: begin
               if (handed) begin
                  left_reg <= left_reg - 1'b1;
               end
               if (loadHead) begin
                  {cbe_reg, ad_reg} <= fifoData;
                  headValid_reg <= 1'b1;
               end else if (handed) begin
                  headValid_reg <= 1'b0;
               end
               if (lm.local_master_state == STAT_BUS_TERM) begin
                  headValid_reg <= 1'b0;
                  done_reg <= 1'b1;
                  state_reg <= LM_IDLE;
               end
            end
         endcase
         if (state_reg == LM_HIGH && loadHead) begin
            {cbe_reg, ad_reg} <= fifoData;
            headValid_reg <= 1'b1;
         end
      end
   end
endmodule // local_master_end

// ### pci_dac_write_master.sv
// PCI master sequencer for 32-bit dual-address-cycle burst writes.
`timescale 1ns/1ns
module pci_dac_write_master
   import pci_dac_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   local_master_if.device lm,
   output logic pciReqN,
   input wire logic pciGntN,
   input wire logic frameIn,
   output logic frameOut,
   output logic frameOe,
   input wire logic irdyIn,
   output logic irdyOut,
   output logic irdyOe,
   input wire logic trdyN,
   input wire logic [ADDR_W-1:0] adIn,
   output logic [ADDR_W-1:0] adOut,
   output logic adOe,
   input wire logic [BE_W-1:0] cbeIn,
   output logic [BE_W-1:0] cbeOut,
   output logic cbeOe
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_REQ, ST_LOAD, ST_LOW, ST_HIGH, ST_WAIT, ST_DATA, ST_TURN
   } seq_state_type;
   seq_state_type state_reg;            // Transaction sequence.
   logic reqN_reg;                      // Bus request to the arbiter.
   logic grantN_reg;                    // Local grant indication.
   logic [3:0] status_reg;              // Local status code.
   logic [1:0] reason_reg;              // Termination reason.
   logic [ADDR_W-1:0] addrLo_reg;       // Latched low start address.
   logic [BE_W-1:0] cmd_reg;            // Latched bus command.
   logic [LEN_W-1:0] len_reg;           // Latched burst length.
   logic [LEN_W-1:0] count_reg;         // Data phases still due.
   logic [LEN_W-1:0] takeLeft_reg;      // Words still to take locally.
   logic takenN_reg;                    // Word taken strobe.
   logic [ADDR_W-1:0] ad_reg;           // Word driven on AD.
   logic [BE_W-1:0] cbe_reg;            // Value driven on C/BE#.
   logic busOe_reg;                     // AD and C/BE# driven.
   logic frameN_reg;                    // FRAME# level.
   logic frameOe_reg;                   // FRAME# driven.
   logic irdyN_reg;                     // IRDY# level.
   logic irdyOe_reg;                    // IRDY# driven.
   logic [WORD_W-1:0] queue [QUEUE_DEPTH]; // Words taken, not yet on AD.
   logic [1:0] wrPtr_reg;               // Queue write slot.
   logic [1:0] rdPtr_reg;               // Queue read slot.
   logic [2:0] qCount_reg;              // Queue fill level.
   logic push;                          // A local word is captured.
   logic phaseDone;                     // A data phase completes.
   logic loadWord;                      // Next queued word goes on AD.
   logic [LEN_W-1:0] takeAfter;         // Words left after this push.

   // A word counts only when the strobe and ready coincide.
   assign push = !takenN_reg && !lm.local_ready_n;
   // Both ready lines low completes a data phase.
   assign phaseDone = state_reg == ST_DATA && !irdyN_reg && !trdyN;
   // Load after a completed phase or while IRDY# waits for a word.
   assign loadWord = qCount_reg != 3'h0 && (state_reg == ST_WAIT ||
      (state_reg == ST_DATA &&
      (phaseDone ? count_reg != LEN_W'(1) : irdyN_reg)));
   assign takeAfter = push ? takeLeft_reg - 1'b1 : takeLeft_reg;

   assign pciReqN = reqN_reg;
   assign frameOut = frameN_reg;
   assign frameOe = frameOe_reg;
   assign irdyOut = irdyN_reg;
   assign irdyOe = irdyOe_reg;
   assign adOut = ad_reg;
   assign adOe = busOe_reg;
   assign cbeOut = cbe_reg;
   assign cbeOe = busOe_reg;
   assign lm.local_grant_n = grantN_reg;
   assign lm.local_master_state = status_reg;
   assign lm.local_word_taken_n = takenN_reg;
   assign lm.local_end_reason = reason_reg;
   assign lm.remaining_burst_count = count_reg;

   // Bus request follows the local request and ends once framed.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reqN_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && !lm.local_req_32bit_n) begin
         reqN_reg <= 1'b0;
      end else if (frameOe_reg && !frameN_reg && lm.local_req_32bit_n) begin
         reqN_reg <= 1'b1;
      end else if (state_reg == ST_TURN ||
         (state_reg == ST_REQ && lm.local_req_32bit_n)) begin
         reqN_reg <= 1'b1;
      end
   end

   // Local grant reflects a bus grant while the bus lies idle.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         grantN_reg <= 1'b1;
      end else begin
         grantN_reg <= !(state_reg == ST_REQ && !pciGntN && frameIn &&
            irdyIn);
      end
   end

   // Word taken strobe paces the local master.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         takenN_reg <= 1'b1;
      end else if (takeAfter == '0) begin
         takenN_reg <= 1'b1;
      end else if (state_reg == ST_LOW || state_reg == ST_HIGH) begin
         takenN_reg <= lm.local_ready_n;
      end else if (state_reg == ST_WAIT && !takenN_reg) begin
         takenN_reg <= 1'b1;
      end else if (state_reg == ST_WAIT || state_reg == ST_DATA) begin
         // Take after ready and TRDY#, or when the queue ran dry.
         takenN_reg <= !(!lm.local_ready_n &&
            (!trdyN || qCount_reg == 3'h0));
      end else begin
         takenN_reg <= 1'b1;
      end
   end

   // Queue storage is written without reset.
   always_ff @(posedge clock) begin
      if (push) begin
         queue[wrPtr_reg] <= {lm.local_cmd_byte_en_in, lm.localAdIn};
      end
   end

   // Queue pointers and the count of words still to take.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         qCount_reg <= '0;
         takeLeft_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (loadWord) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (push && !loadWord) begin
            qCount_reg <= qCount_reg + 1'b1;
         end else if (loadWord && !push) begin
            qCount_reg <= qCount_reg - 1'b1;
         end
         if (state_reg == ST_LOAD) begin
            takeLeft_reg <= len_reg;
         end else begin
            takeLeft_reg <= takeAfter;
         end
      end
   end

   // Main sequence: addresses, data phases and bus release.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         status_reg <= STAT_IDLE;
         reason_reg <= END_NONE;
         addrLo_reg <= '0;
         cmd_reg <= '0;
         len_reg <= '0;
         count_reg <= '0;
         ad_reg <= '0;
         cbe_reg <= '0;
         busOe_reg <= 1'b0;
         frameN_reg <= 1'b1;
         frameOe_reg <= 1'b0;
         irdyN_reg <= 1'b1;
         irdyOe_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               irdyOe_reg <= 1'b0;
               status_reg <= STAT_IDLE;
               if (!lm.local_req_32bit_n) begin
                  state_reg <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (!grantN_reg && !lm.local_req_32bit_n) begin
                  // Latch the start parameters.
                  addrLo_reg <= lm.localAdIn;
                  cmd_reg <= lm.local_cmd_byte_en_in;
                  len_reg <= lm.local_burst_len;
                  reason_reg <= END_NONE;
                  status_reg <= STAT_ADDR_LOAD;
                  state_reg <= ST_LOAD;
               end else if (lm.local_req_32bit_n) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_LOAD: begin
               // Low address cycle with the DAC command.
               frameN_reg <= 1'b0;
               frameOe_reg <= 1'b1;
               ad_reg <= addrLo_reg;
               cbe_reg <= cmd_reg;
               busOe_reg <= 1'b1;
               irdyN_reg <= 1'b1;
               irdyOe_reg <= 1'b1;
               count_reg <= len_reg;
               state_reg <= ST_LOW;
            end
            ST_LOW: begin
               // High address cycle with the real command.
               ad_reg <= lm.localAdIn;
               cbe_reg <= lm.local_cmd_byte_en_in;
               status_reg <= STAT_BUS_TRANS;
               state_reg <= ST_HIGH;
            end
            ST_HIGH: begin
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (loadWord) begin
                  {cbe_reg, ad_reg} <= queue[rdPtr_reg];
                  irdyN_reg <= 1'b0;
                  frameN_reg <= count_reg == LEN_W'(1);
                  state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (phaseDone) begin
                  count_reg <= count_reg - 1'b1;
               end
               if (phaseDone && count_reg == LEN_W'(1)) begin
                  // Release the bus and report the ending.
                  frameN_reg <= 1'b1;
                  frameOe_reg <= 1'b0;
                  busOe_reg <= 1'b0;
                  irdyN_reg <= 1'b1;
                  count_reg <= '0;
                  status_reg <= STAT_BUS_TERM;
                  reason_reg <= END_NORMAL;
                  state_reg <= ST_TURN;
               end else if (loadWord) begin
                  // Next word on AD; IRDY# stays asserted.
                  {cbe_reg, ad_reg} <= queue[rdPtr_reg];
                  irdyN_reg <= 1'b0;
                  frameN_reg <= (phaseDone ? count_reg - 1'b1 : count_reg)
                     == LEN_W'(1);
               end else if (phaseDone) begin
                  irdyN_reg <= 1'b1;
               end
            end
            default: begin
               // IRDY# is released one cycle after the turnaround.
               irdyOe_reg <= 1'b0;
               status_reg <= STAT_IDLE;
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // pci_dac_write_master

// ### pci_dac_props.sv
// Assertions on the local link and PCI outputs of the write sequencer.
`timescale 1ns/1ns
module pci_dac_props
   import pci_dac_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic local_req_32bit_n,
   input wire logic [LEN_W-1:0] local_burst_len,
   input wire logic local_grant_n,
   input wire logic [3:0] local_master_state,
   input wire logic local_word_taken_n,
   input wire logic [1:0] local_end_reason,
   input wire logic [LEN_W-1:0] remaining_burst_count,
   input wire logic pciReqN,
   input wire logic pciGntN,
   input wire logic frameOut,
   input wire logic frameOe,
   input wire logic irdyOut,
   input wire logic irdyOe,
   input wire logic trdyN,
   input wire logic [BE_W-1:0] cbeOut,
   input wire logic adOe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   logic lastPhase; // The sequencer presents its final word.
   assign lastPhase = frameOe && frameOut && irdyOe && !irdyOut;
   a_bus_req_rise: assert property ($fell(local_req_32bit_n) |=> !pciReqN)
      else $error("bus request did not follow local request");
   a_local_grant: assert property ($fell(pciGntN) &&
      local_master_state == STAT_IDLE |=> !local_grant_n)
      else $error("local grant missing after bus grant");
   a_load_state: assert property (!local_req_32bit_n && !local_grant_n &&
      local_master_state == STAT_IDLE |=> local_master_state == STAT_ADDR_LOAD)
      else $error("address loading state not entered");
   a_low_addr: assert property ($rose(local_master_state == STAT_ADDR_LOAD)
      |=> !frameOut && frameOe && adOe && cbeOut == CMD_DAC &&
      local_master_state == STAT_ADDR_LOAD &&
      remaining_burst_count == $past(local_burst_len))
      else $error("low address cycle wrong");
   a_high_addr: assert property (local_master_state == STAT_ADDR_LOAD &&
      frameOe && !frameOut |=> !frameOut && adOe &&
      local_master_state == STAT_BUS_TRANS)
      else $error("high address cycle wrong");
   a_req_drop: assert property (frameOe && !frameOut && local_req_32bit_n
      |=> pciReqN)
      else $error("bus request held without local request");
   a_count_step: assert property (irdyOe && !irdyOut && !trdyN |=>
      remaining_burst_count == $past(remaining_burst_count) - 11'h1)
      else $error("burst count did not step down");
   a_last_taken: assert property (lastPhase |-> local_word_taken_n)
      else $error("word strobe active in last phase");
   a_turnaround: assert property (lastPhase && !trdyN |=> !frameOe &&
      !adOe && irdyOe && irdyOut && remaining_burst_count == 11'h0 &&
      local_master_state == STAT_BUS_TERM && local_end_reason == END_NORMAL
      ##1 !irdyOe && local_master_state == STAT_IDLE)
      else $error("turnaround cycle wrong");
endmodule // pci_dac_props

// ### tb_top.sv
// Testbench joining both ends and playing arbiter and target.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin numErrors++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top
   import pci_dac_pkg::*;
;
   logic clock, arst_n, userStart, userBusy, userDone, wrValid, wrReady;
   logic [63:0] userAddr;
   logic [LEN_W-1:0] userLen;
   logic [WORD_W-1:0] wrData;
   logic pciReqN, pciGntN, frameOut, frameOe, irdyOut, irdyOe, trdyN;
   logic adOe, cbeOe, stallOn, hiNext;
   logic [31:0] adOut, seenLo, seenHi;
   logic [3:0] cbeOut, cmdLo, cmdHi;
   logic [WORD_W-1:0] got[$]; // Words seen in completed data phases.
   int numErrors = 0, checked = 0, cycles = 0;
   local_master_if lmIf();
   local_master_end local_master_end_i(.clock(clock), .arst_n(arst_n),
      .lm(lmIf), .userStart(userStart), .userAddr(userAddr),
      .userLen(userLen), .userBusy(userBusy), .userDone(userDone),
      .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady));
   // Released lines: pull-ups on the controls, inverted last value on AD.
   pci_dac_write_master pci_dac_write_master_i(.clock(clock),
      .arst_n(arst_n), .lm(lmIf), .pciReqN(pciReqN), .pciGntN(pciGntN),
      .frameIn(frameOe ? frameOut : 1'b1), .frameOut(frameOut),
      .frameOe(frameOe), .irdyIn(irdyOe ? irdyOut : 1'b1),
      .irdyOut(irdyOut), .irdyOe(irdyOe), .trdyN(trdyN),
      .adIn(adOe ? adOut : ~adOut), .adOut(adOut), .adOe(adOe),
      .cbeIn(cbeOe ? cbeOut : ~cbeOut), .cbeOut(cbeOut), .cbeOe(cbeOe));
   pci_dac_props pci_dac_props_i(.clock(clock), .arst_n(arst_n),
      .local_req_32bit_n(lmIf.local_req_32bit_n),
      .local_burst_len(lmIf.local_burst_len),
      .local_grant_n(lmIf.local_grant_n),
      .local_master_state(lmIf.local_master_state),
      .local_word_taken_n(lmIf.local_word_taken_n),
      .local_end_reason(lmIf.local_end_reason),
      .remaining_burst_count(lmIf.remaining_burst_count),
      .pciReqN(pciReqN), .pciGntN(pciGntN), .frameOut(frameOut),
      .frameOe(frameOe), .irdyOut(irdyOut), .irdyOe(irdyOe),
      .trdyN(trdyN), .cbeOut(cbeOut), .adOe(adOe));
   // Clock of 10 ns period.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Arbiter grants a cycle after request; target ready unless stalling.
   always @(posedge clock) begin
      pciGntN <= pciReqN;
      trdyN <= (frameOe ? frameOut : 1'b1) && (irdyOe ? irdyOut : 1'b1)
         || (stallOn && cycles[1]);
   end
   // Records both address cycles and every completed data phase.
   always @(posedge clock) begin
      if (hiNext) begin
         seenHi = adOut;
         cmdHi = cbeOut;
      end
      hiNext = lmIf.local_master_state == STAT_ADDR_LOAD && frameOe &&
         !frameOut;
      if (hiNext) begin
         seenLo = adOut;
         cmdLo = cbeOut;
      end
      if (irdyOe && !irdyOut && !trdyN) got.push_back({cbeOut, adOut});
      cycles++;
      if (cycles == 2000) begin
         numErrors++;
         finish_test();
      end
   end
   // Test pattern: byte enables above the data word.
   function automatic logic [WORD_W-1:0] word(input int i);
      return {4'hf - 4'(i), 32'h5a00_0000 + 32'(i)};
   endfunction
   // Pushes words first..first+cnt-1 into the write FIFO.
   task automatic feed(input int first, input int cnt);
      int k;
      for (int i = first; i < first + cnt; i++) begin
         wrData <= word(i);
         wrValid <= 1'b1;
         k = 0;
         do begin
            @(posedge clock);
            k++;
         end while (!wrReady && k < 200);
      end
      wrValid <= 1'b0;
   endtask
   // One burst: pre words buffered before start, the rest during it.
   task automatic run(input logic [63:0] a, input int len, input int pre,
      input logic st);
      int n;
      got.delete();
      stallOn <= st;
      feed(0, pre);
      @(posedge clock);
      if (pre == FIFO_DEPTH) `CHK("fifo full", 1'b0, wrReady)
      userAddr <= a;
      userLen <= LEN_W'(len);
      userStart <= 1'b1;
      @(posedge clock);
      userStart <= 1'b0;
      n = 0;
      fork
         feed(pre, len - pre);
         while (!userDone && n < 500) begin
            @(posedge clock);
            n++;
         end
      join
      `CHK("done", 1'b1, userDone)
      `CHK("busy", 1'b0, userBusy)
      `CHK("low address", a[31:0], seenLo)
      `CHK("dac command", CMD_DAC, cmdLo)
      `CHK("high address", a[63:32], seenHi)
      `CHK("high command", CMD_MEM_WRITE, cmdHi)
      `CHK("phases", len, got.size())
      foreach (got[i]) `CHK("word", word(i), got[i])
   endtask
   // Prints the counts and the verdict, then stops.
   task finish_test();
      $display("errors %0d checks %0d", numErrors, checked);
      if (numErrors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Full buffer, single word, trickled data with stalls, back to back.
   initial begin
      arst_n = 1'b0;
      userStart = 1'b0;
      userAddr = 64'h0;
      userLen = 11'h0;
      wrData = 36'h0;
      wrValid = 1'b0;
      pciGntN = 1'b1;
      trdyN = 1'b1;
      stallOn = 1'b0;
      hiNext = 1'b0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      run(64'h0000_0012_3456_7800, FIFO_DEPTH, FIFO_DEPTH, 1'b0);
      run(64'hffff_fff0_0000_0004, 1, 1, 1'b0);
      run(64'h0000_0001_8000_0010, 5, 0, 1'b1);
      run(64'h0000_0002_0000_0020, 3, 2, 1'b1);
      finish_test();
   end
endmodule // tb_top
